/* File: aisc_input_stage.v */
// Input stage and power-down configuration register bank with decoded outputs
`timescale 1ns/1ps
module aisc_input_stage
(
    input wire mclk_i,
    input wire reset_n_i,
    input wire [7:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    output reg per_channel_amp_gain_enable_o,
    output reg [1:0] global_amp_gain_o,
    output reg amp_gain_reserved_o,
    output reg amp_highpass_disable_o,
    output reg [1:0] input_clamp_level_o,
    output reg active_termination_enable_o,
    output reg [4:0] termination_code_o,
    output reg termination_high_z_o,
    output reg global_power_down_o,
    output reg quick_wake_power_down_o,
    output reg amp_power_down_o,
    output reg attenuator_gain_stage_power_down_o,
    output reg [1:0] power_mode_select_o,
    output reg low_noise_figure_enable_o,
    output reg [7:0] pair_power_down_o
);
`include "aisc_defines.vh"
    reg [15:0] input_cfg_reg;
    reg [15:0] power_down_reg;
    reg [15:0] rdata_next;
    reg [4:0] term_code_next;
    wire [4:0] auto_code;
    wire [1:0] gain_sel;
    wire [1:0] gterm_sel;
    wire ind_en;
    wire [4:0] ind_code;

    assign gain_sel = input_cfg_reg[`AISC_GAIN_HI:`AISC_GAIN_LO];
    assign gterm_sel = input_cfg_reg[`AISC_GTERM_HI:`AISC_GTERM_LO];
    assign ind_en = input_cfg_reg[`AISC_IND_RES_EN_BIT];
    assign ind_code = input_cfg_reg[`AISC_IND_RES_HI:`AISC_IND_RES_LO];

    aisc_term_map aisc_term_map_i
    (
        .gain_i(gain_sel),
        .sel_i(gterm_sel),
        .code_o(auto_code)
    );

    always @*
    begin
        // Individual code overrides the automatic mapping only when enabled
        if (ind_en)
        begin
            term_code_next = ind_code;
        end
        else
        begin
            term_code_next = auto_code;
        end
    end

    always @*
    begin
        case (addr_i)
            `AISC_INPUT_CFG_ADDR: rdata_next = input_cfg_reg;
            `AISC_POWER_DOWN_ADDR: rdata_next = power_down_reg;
            default: rdata_next = `AISC_UNMAPPED_DATA;
        endcase
    end

    // All bits are stored as written; reserved values are flagged, not blocked
    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            input_cfg_reg <= `AISC_INPUT_CFG_RESET;
        end
        else if (wr_i && addr_i == `AISC_INPUT_CFG_ADDR)
        begin
            input_cfg_reg <= wdata_i;
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            power_down_reg <= `AISC_POWER_DOWN_RESET;
        end
        else if (wr_i && addr_i == `AISC_POWER_DOWN_ADDR)
        begin
            power_down_reg <= wdata_i;
        end
    end

    // Read data stands only in the cycle after the strobe, so stale words never linger
    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_o <= 16'h0000;
        end
        else if (rd_i)
        begin
            rdata_o <= rdata_next;
        end
        else
        begin
            rdata_o <= 16'h0000;
        end
    end

    // Decoded outputs lag the register by one cycle so every output is a flop
    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            per_channel_amp_gain_enable_o <= 1'b0;
        end
        else
        begin
            per_channel_amp_gain_enable_o <= input_cfg_reg[`AISC_PERCH_GAIN_BIT];
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            global_amp_gain_o <= 2'b00;
        end
        else
        begin
            global_amp_gain_o <= gain_sel;
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            amp_gain_reserved_o <= 1'b0;
        end
        else
        begin
            amp_gain_reserved_o <= (gain_sel == `AISC_GAIN_RSVD);
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            amp_highpass_disable_o <= 1'b0;
        end
        else
        begin
            amp_highpass_disable_o <= input_cfg_reg[`AISC_HPF_DIS_BIT];
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            input_clamp_level_o <= 2'b00;
        end
        else
        begin
            input_clamp_level_o <= input_cfg_reg[`AISC_CLAMP_HI:`AISC_CLAMP_LO];
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            active_termination_enable_o <= 1'b0;
        end
        else
        begin
            active_termination_enable_o <= input_cfg_reg[`AISC_TERM_EN_BIT];
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            termination_code_o <= 5'h00;
        end
        else
        begin
            termination_code_o <= term_code_next;
        end
    end

    // High impedance during reset matches the zero code held there
    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            termination_high_z_o <= 1'b1;
        end
        else
        begin
            termination_high_z_o <= (term_code_next == `AISC_CODE_HIGHZ);
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            global_power_down_o <= 1'b0;
        end
        else
        begin
            global_power_down_o <= power_down_reg[`AISC_GLOBAL_POWER_DOWN_BIT];
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            quick_wake_power_down_o <= 1'b0;
        end
        else
        begin
            quick_wake_power_down_o <= power_down_reg[`AISC_QUICK_PDWN_BIT];
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            amp_power_down_o <= 1'b0;
        end
        else
        begin
            amp_power_down_o <= power_down_reg[`AISC_AMP_PDWN_BIT];
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            attenuator_gain_stage_power_down_o <= 1'b0;
        end
        else
        begin
            attenuator_gain_stage_power_down_o <= power_down_reg[`AISC_ATT_PDWN_BIT];
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            power_mode_select_o <= 2'b00;
        end
        else
        begin
            power_mode_select_o <= power_down_reg[`AISC_PMODE_HI:`AISC_PMODE_LO];
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            low_noise_figure_enable_o <= 1'b0;
        end
        else
        begin
            low_noise_figure_enable_o <= power_down_reg[`AISC_LOW_NOISE_FIGURE_ENABLE_BIT];
        end
    end

    // One flop per channel pair; each pair powers down on its own bit
    genvar pair_idx;
    generate
        for (pair_idx = 0; pair_idx < 8; pair_idx = pair_idx + 1)
        begin
            always @(posedge mclk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                begin
                    pair_power_down_o[pair_idx] <= 1'b0;
                end
                else
                begin
                    pair_power_down_o[pair_idx] <= power_down_reg[`AISC_PAIR_LO + pair_idx];
                end
            end
        end
    endgenerate
endmodule

/* File: aisc_defines.vh */
// Register offsets, field positions, reset values and decode constants
`ifndef AISC_DEFINES_VH
`define AISC_DEFINES_VH
`define AISC_ADDR_W 8
`define AISC_DATA_W 16
`define AISC_INPUT_CFG_ADDR 8'hC4
`define AISC_POWER_DOWN_ADDR 8'hC5
`define AISC_INPUT_CFG_RESET 16'h0000
`define AISC_POWER_DOWN_RESET 16'h0000
`define AISC_UNMAPPED_DATA 16'h0000
`define AISC_PERCH_GAIN_BIT 15
`define AISC_GAIN_HI 14
`define AISC_GAIN_LO 13
`define AISC_HPF_DIS_BIT 12
`define AISC_CFG_SPARE_BIT 11
`define AISC_CLAMP_HI 10
`define AISC_CLAMP_LO 9
`define AISC_TERM_EN_BIT 8
`define AISC_GTERM_HI 7
`define AISC_GTERM_LO 6
`define AISC_IND_RES_EN_BIT 5
`define AISC_IND_RES_HI 4
`define AISC_IND_RES_LO 0
`define AISC_GLOBAL_POWER_DOWN_BIT 15
`define AISC_QUICK_PDWN_BIT 14
`define AISC_AMP_PDWN_BIT 13
`define AISC_ATT_PDWN_BIT 12
`define AISC_PMODE_HI 11
`define AISC_PMODE_LO 10
`define AISC_LOW_NOISE_FIGURE_ENABLE_BIT 9
`define AISC_PD_ZERO_BIT 8
`define AISC_PAIR_HI 7
`define AISC_PAIR_LO 0
`define AISC_GAIN_18DB 2'b00
`define AISC_GAIN_24DB 2'b01
`define AISC_GAIN_12DB 2'b10
`define AISC_GAIN_RSVD 2'b11
`define AISC_GTERM_50 2'b00
`define AISC_CODE_HIGHZ 5'h00
`define AISC_CODE_50 5'h01
`define AISC_CODE_100 5'h02
`define AISC_CODE_200 5'h04
`define AISC_CODE_400 5'h08
`define AISC_CODE_150 5'h01
`define AISC_CODE_300 5'h02
`define AISC_CODE_600 5'h04
`define AISC_CODE_90 5'h01
`define AISC_CODE_180 5'h02
`define AISC_CODE_360 5'h04
`define AISC_CODE_720 5'h08
`define AISC_CODE_1200 5'h08
`endif

/* File: aisc_term_map.v */
// Combinational map from global termination select and amp gain to resistor code
`timescale 1ns/1ps
module aisc_term_map
(
    input wire [1:0] gain_i,
    input wire [1:0] sel_i,
    output reg [4:0] code_o
);
`include "aisc_defines.vh"
    always @*
    begin
        code_o = `AISC_CODE_HIGHZ;
        case (gain_i)
            `AISC_GAIN_24DB:
            begin
                // 50, 100, 200, 400 ohm map to one resistor branch each
                case (sel_i)
                    2'b00: code_o = `AISC_CODE_50;
                    2'b01: code_o = `AISC_CODE_100;
                    2'b10: code_o = `AISC_CODE_200;
                    default: code_o = `AISC_CODE_400;
                endcase
            end
            `AISC_GAIN_18DB:
            begin
                // No exact 50, 100 or 200 ohm code at 18 dB; the nearest impedance is used
                case (sel_i)
                    2'b00: code_o = 5'h07;
                    2'b01: code_o = 5'h0E;
                    2'b10: code_o = 5'h1C;
                    default: code_o = 5'h18;
                endcase
            end
            `AISC_GAIN_12DB:
            begin
                case (sel_i)
                    2'b00: code_o = `AISC_CODE_HIGHZ;
                    2'b01: code_o = 5'h03;
                    2'b10: code_o = 5'h06;
                    default: code_o = 5'h0C;
                endcase
            end
            default: code_o = `AISC_CODE_HIGHZ;
        endcase
    end
endmodule

/* File: aisc_input_stage_checker.sv */
// Assertion checker bound to the input stage register bank
`timescale 1ns/1ps
`include "aisc_defines.vh"
module aisc_input_stage_checker
(
    input wire mclk_i,
    input wire reset_n_i,
    input wire [7:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [15:0] rdata_o,
    input wire per_channel_amp_gain_enable_o,
    input wire [1:0] global_amp_gain_o,
    input wire amp_gain_reserved_o,
    input wire amp_highpass_disable_o,
    input wire [1:0] input_clamp_level_o,
    input wire active_termination_enable_o,
    input wire [4:0] termination_code_o,
    input wire termination_high_z_o,
    input wire global_power_down_o,
    input wire quick_wake_power_down_o,
    input wire amp_power_down_o,
    input wire attenuator_gain_stage_power_down_o,
    input wire [1:0] power_mode_select_o,
    input wire low_noise_figure_enable_o,
    input wire [7:0] pair_power_down_o
);
    wire c4_wr = wr_i && addr_i == `AISC_INPUT_CFG_ADDR;
    wire [14:0] pd_w = {global_power_down_o, quick_wake_power_down_o, amp_power_down_o,
        attenuator_gain_stage_power_down_o, power_mode_select_o, low_noise_figure_enable_o,
        pair_power_down_o};
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    pd_write_a: assert property (wr_i && addr_i == `AISC_POWER_DOWN_ADDR |=> ##1
        pd_w == {$past(wdata_i[15:9], 2), $past(wdata_i[7:0], 2)}) else $error("pd outputs");
    pd_read_a: assert property (rd_i && addr_i == `AISC_POWER_DOWN_ADDR |=>
        {rdata_o[15:9], rdata_o[7:0]} == pd_w) else $error("pd read");
    cfg_write_a: assert property (c4_wr |=> ##1
        {per_channel_amp_gain_enable_o, global_amp_gain_o, amp_highpass_disable_o,
        input_clamp_level_o, active_termination_enable_o}
        == {$past(wdata_i[15:12], 2), $past(wdata_i[10:8], 2)}) else $error("cfg outputs");
    ind_code_a: assert property (c4_wr && wdata_i[5] |=> ##1
        termination_code_o == $past(wdata_i[4:0], 2)) else $error("individual code");
    gain12_highz_a: assert property (
        c4_wr && wdata_i[14:13] == 2'b10 && wdata_i[7:5] == 3'b000 |=> ##1
        termination_high_z_o) else $error("12 dB high-z");
    high_z_a: assert property (termination_high_z_o == (termination_code_o == 5'h00))
        else $error("high-z flag");
    rsvd_flag_a: assert property (amp_gain_reserved_o == (global_amp_gain_o == 2'b11))
        else $error("reserved flag");
    // C4h and C5h differ only in bit 0
    unmapped_read_a: assert property (rd_i && addr_i[7:1] != 7'h62 |=>
        rdata_o == 16'h0000) else $error("unmapped read");
    idle_rdata_a: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data outside read cycle");
endmodule
bind aisc_input_stage aisc_input_stage_checker aisc_input_stage_checker_i
(
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .per_channel_amp_gain_enable_o(per_channel_amp_gain_enable_o),
    .global_amp_gain_o(global_amp_gain_o),
    .amp_gain_reserved_o(amp_gain_reserved_o),
    .amp_highpass_disable_o(amp_highpass_disable_o),
    .input_clamp_level_o(input_clamp_level_o),
    .active_termination_enable_o(active_termination_enable_o),
    .termination_code_o(termination_code_o),
    .termination_high_z_o(termination_high_z_o),
    .global_power_down_o(global_power_down_o),
    .quick_wake_power_down_o(quick_wake_power_down_o),
    .amp_power_down_o(amp_power_down_o),
    .attenuator_gain_stage_power_down_o(attenuator_gain_stage_power_down_o),
    .power_mode_select_o(power_mode_select_o),
    .low_noise_figure_enable_o(low_noise_figure_enable_o),
    .pair_power_down_o(pair_power_down_o)
);

/* File: aisc_input_stage_tb_top.sv */
// Self-checking bench for the input stage register bank
`timescale 1ns/1ps
`include "aisc_defines.vh"
module aisc_input_stage_tb_top;
    localparam [59:0] AUTO_MAP = {5'h0C, 5'h06, 5'h03, 5'h00, 5'h08, 5'h04, 5'h02, 5'h01,
        5'h18, 5'h1C, 5'h0E, 5'h07};
    // Patterns keep C4h bit 11 and C5h bit 8 at zero and never write the reserved gain
    localparam [63:0] CFG_PATS = {16'h0000, 16'h4155, 16'hA2AA, 16'hD7FF};
    localparam [63:0] PD_PATS = {16'h0000, 16'h5455, 16'hA8AA, 16'hF2FF};
    reg mclk_i = 1'b0;
    reg reset_n_i = 1'b0;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg [7:0] addr_i = 8'h00;
    reg [15:0] wdata_i = 16'h0000;
    reg [15:0] p;
    reg [15:0] q;
    reg [4:0] e;
    wire [15:0] rdata_o;
    wire [7:0] pair_power_down_o;
    wire [4:0] termination_code_o;
    wire [1:0] global_amp_gain_o, input_clamp_level_o, power_mode_select_o;
    wire per_channel_amp_gain_enable_o, amp_gain_reserved_o, amp_highpass_disable_o;
    wire active_termination_enable_o, termination_high_z_o, global_power_down_o;
    wire quick_wake_power_down_o, amp_power_down_o, attenuator_gain_stage_power_down_o;
    wire low_noise_figure_enable_o;
    integer n_mismatch = 0;
    integer checks_done = 0;
    integer cycles = 0;
    integer g;
    aisc_input_stage aisc_input_stage_i
    (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .per_channel_amp_gain_enable_o(per_channel_amp_gain_enable_o),
        .global_amp_gain_o(global_amp_gain_o),
        .amp_gain_reserved_o(amp_gain_reserved_o),
        .amp_highpass_disable_o(amp_highpass_disable_o),
        .input_clamp_level_o(input_clamp_level_o),
        .active_termination_enable_o(active_termination_enable_o),
        .termination_code_o(termination_code_o),
        .termination_high_z_o(termination_high_z_o),
        .global_power_down_o(global_power_down_o),
        .quick_wake_power_down_o(quick_wake_power_down_o),
        .amp_power_down_o(amp_power_down_o),
        .attenuator_gain_stage_power_down_o(attenuator_gain_stage_power_down_o),
        .power_mode_select_o(power_mode_select_o),
        .low_noise_figure_enable_o(low_noise_figure_enable_o),
        .pair_power_down_o(pair_power_down_o)
    );
    initial forever #50 mclk_i = ~mclk_i;
    task chk(input [63:0] what, input [15:0] exp, input [15:0] got);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            $display("mismatch %0s expected %h seen %h", what, exp, got);
            n_mismatch = n_mismatch + 1;
        end
    end
    endtask
    // Waits two edges past the write so the output flops have caught up
    task wr_reg(input [7:0] a, input [15:0] d);
    begin
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
    end
    endtask
    task rd_chk(input [7:0] a, input [15:0] exp);
    begin
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk("read", exp, rdata_o);
    end
    endtask
    task report_and_stop;
    begin
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    always @(posedge mclk_i)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            n_mismatch = n_mismatch + 1;
            report_and_stop;
        end
    end
    initial
    begin
        repeat (12) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rd_chk(`AISC_INPUT_CFG_ADDR, 16'h0000);
        rd_chk(`AISC_POWER_DOWN_ADDR, 16'h0000);
        for (g = 0; g < 12; g = g + 1)
        begin
            wr_reg(`AISC_INPUT_CFG_ADDR, {1'b0, g[3:2], 5'h01, g[1:0], 6'h00});
            e = AUTO_MAP[g*5 +: 5];
            chk("auto", {11'h000, e}, {11'h000, termination_code_o});
            chk("highz", {15'h0000, e == 5'h00}, {15'h0000, termination_high_z_o});
        end
        for (g = 0; g < 32; g = g + 1)
        begin
            wr_reg(`AISC_INPUT_CFG_ADDR, {8'h23, 3'b111, g[4:0]});
            chk("ind", {11'h000, g[4:0]}, {11'h000, termination_code_o});
            chk("highz", {15'h0000, g == 0}, {15'h0000, termination_high_z_o});
        end
        wr_reg(`AISC_INPUT_CFG_ADDR, {8'h23, 3'b110, 5'h1F});
        chk("ind off", 16'h0008, {11'h000, termination_code_o});
        for (g = 0; g < 4; g = g + 1)
        begin
            p = CFG_PATS[g*16 +: 16];
            q = PD_PATS[g*16 +: 16];
            wr_reg(`AISC_INPUT_CFG_ADDR, p);
            wr_reg(`AISC_POWER_DOWN_ADDR, q);
            wr_reg(8'hC6, 16'h1234);
            rd_chk(`AISC_INPUT_CFG_ADDR, p);
            rd_chk(`AISC_POWER_DOWN_ADDR, q);
            chk("cfg out", p & 16'hF700,
                {per_channel_amp_gain_enable_o, global_amp_gain_o, amp_highpass_disable_o,
                1'b0, input_clamp_level_o, active_termination_enable_o, 8'h00});
            chk("pd out", q & 16'hFEFF,
                {global_power_down_o, quick_wake_power_down_o, amp_power_down_o,
                attenuator_gain_stage_power_down_o, power_mode_select_o,
                low_noise_figure_enable_o, 1'b0, pair_power_down_o});
            rd_chk(8'hC6, 16'h0000);
            chk("rsvd", {15'h0000, p[14:13] == 2'b11}, {15'h0000, amp_gain_reserved_o});
        end
        report_and_stop;
    end
endmodule
